// >>> design/rad_top.sv
// operand register and address-mode decoder with an APB register port
// Notes on behaviour
// RULE_01: register code from opcode, reg or rm
// RULE_02: no size bit: full width, 16 under 66H
// RULE_03: size bit zero: low then high bytes
// RULE_04: 66H with size bit one: 16-bit halves
// RULE_05: two-bit segment code: extra, code, stack, data
// RULE_06: three-bit adds fourth, fifth; 110/111 unused
// RULE_07: push/pop use fixed stack addressing
// RULE_08: sib follows when rm 100, mod not 11
// RULE_09: sib address from mod, scale, index, base
// RULE_10: reg field may be opcode extension
// RULE_11: 16-bit or 32-bit addressing interpretation
// RULE_12: component widths follow address size
// RULE_13: mod 00: register or bare d32
// RULE_14: mod 01 d8, 10 d32; frame base stack
// RULE_15: mod 11 selects register operand
// RULE_16: mod 11 under 66H gives 16-bit halves
// RULE_17: prefixes affect only the current instruction
// RULE_18: size bit zero byte, one full size
// RULE_19: decode available as soon as bytes stored
`timescale 1ns/1ps
`default_nettype none
`include "rad_defs.svh"

module rad_top
	import rad_pkg::*;
(
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb request
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`RAD_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	// apb answer
	output logic                        pready,
	output logic                        pslverr,
	output logic [31:0]                 prdata
);

	// ----------------------------------------
	// instruction bytes and prefix state
	// ----------------------------------------
	rad_insn_t   insn_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	rad_reg_t    reg_c;
	rad_ea_t     ea_c;
	logic        setup;
	logic        wr_now;
	logic        mapped;

	assign setup  = psel && !penable;
	assign wr_now = psel && penable && pready_q && pwrite;
	assign mapped = (paddr == `RAD_OFF_INSN) || (paddr == `RAD_OFF_REG)
		|| (paddr == `RAD_OFF_EA);

	// prefixes live in the written word, so each new word is a new instruction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			insn_q <= `RAD_INSN_RST;
		end else if (wr_now && paddr == `RAD_OFF_INSN) begin
			insn_q <= pwdata; // see RULE_17
		end
	end

	// ----------------------------------------
	// register selection
	// ----------------------------------------
	function automatic rad_regsel_t pick_reg(input logic [2:0] code,
		input logic wp, input logic w, input logic p66);
		rad_regsel_t r;
		r.idx   = code;
		r.width = p66 ? RAD_W_16 : RAD_W_32; // see RULE_02 see RULE_04
		if (wp && !w) begin // see RULE_18
			r.width = code[2] ? RAD_W_BHI : RAD_W_BLO; // see RULE_03
			r.idx   = {1'b0, code[1:0]};
		end
		return r;
	endfunction : pick_reg

	// decode is combinational on the stored bytes; see RULE_19
	always_comb begin
		logic [2:0] code;
		code  = insn_q.op_reg;
		reg_c = '0;
		unique case (insn_q.reg_src) // see RULE_01
			RAD_SRC_OPC:  code = insn_q.op_reg;
			RAD_SRC_MREG: code = insn_q.modrm[5:3];
			RAD_SRC_MRM:  code = insn_q.modrm[2:0];
			default:      code = insn_q.op_reg;
		endcase
		reg_c.sel = pick_reg(code, insn_q.w_present, insn_q.w, insn_q.p66);
		reg_c.reg_ok = 1'b1;
		if (insn_q.reg_src == RAD_SRC_MREG && insn_q.reg_is_ext) begin
			reg_c.reg_ok = 1'b0; // see RULE_10
		end
		if (insn_q.reg_src == RAD_SRC_MRM && insn_q.modrm[7:6] != 2'h3) begin
			reg_c.reg_ok = 1'b0;
		end
		if (insn_q.seg3) begin
			reg_c.seg     = rad_seg_t'(insn_q.seg_code); // see RULE_06
			reg_c.seg_bad = insn_q.seg_code[2] && insn_q.seg_code[1];
		end else begin
			reg_c.seg = rad_seg_t'({1'b0, insn_q.seg_code[1:0]}); // see RULE_05
		end
	end

	// ----------------------------------------
	// effective address form
	// ----------------------------------------
	always_comb begin
		logic [1:0] md;
		logic [2:0] rm;
		logic [2:0] sbase;
		logic [2:0] sidx;
		md    = insn_q.modrm[7:6];
		rm    = insn_q.modrm[2:0];
		sbase = insn_q.sib[2:0];
		sidx  = insn_q.sib[5:3];
		ea_c  = '0;
		ea_c.a16 = insn_q.a16;
		ea_c.fixed_addr = insn_q.fixed_addr;
		ea_c.seg = RAD_S_DATA;
		if (insn_q.fixed_addr) begin
			ea_c.seg     = RAD_S_STACK; // see RULE_07
			ea_c.base    = `RAD_IDX_SP;
			ea_c.base_ok = 1'b1;
		end else if (md == 2'h3) begin
			ea_c.reg_direct = 1'b1; // see RULE_15 see RULE_16
			ea_c.rm_sel = pick_reg(rm, insn_q.w_present, insn_q.w, insn_q.p66);
		end else if (insn_q.a16) begin
			// only the displacement width of the 16-bit forms is resolved here
			if (md == 2'h1) begin
				ea_c.disp = RAD_D_8; // see RULE_11 see RULE_12
			end else if (md == 2'h2 || rm == `RAD_CODE_D16) begin
				ea_c.disp = RAD_D_16;
			end
		end else if (rm == `RAD_CODE_SIB) begin
			ea_c.sib_need = 1'b1; // see RULE_08
			ea_c.scale    = insn_q.sib[7:6]; // see RULE_09
			ea_c.idx      = sidx;
			ea_c.idx_ok   = sidx != `RAD_IDX_SP;
			ea_c.base     = sbase;
			ea_c.base_ok  = !(md == 2'h0 && sbase == `RAD_CODE_FRM);
			ea_c.disp     = md == 2'h1 ? RAD_D_8 : RAD_D_32;
			if (md == 2'h0) begin
				ea_c.disp = sbase == `RAD_CODE_FRM ? RAD_D_32 : RAD_D_NONE;
			end
			if (sbase == `RAD_IDX_SP || (sbase == `RAD_CODE_FRM && md != 2'h0)) begin
				ea_c.seg = RAD_S_STACK;
			end
		end else begin
			ea_c.base    = rm; // see RULE_12
			ea_c.base_ok = 1'b1;
			unique case (md)
				2'h0: begin
					if (rm == `RAD_CODE_FRM) begin
						ea_c.base_ok = 1'b0; // see RULE_13
						ea_c.disp    = RAD_D_32;
					end
				end
				2'h1: ea_c.disp = RAD_D_8; // see RULE_14
				2'h2: ea_c.disp = RAD_D_32;
				default: ea_c.disp = RAD_D_NONE;
			endcase
			if (md != 2'h0 && rm == `RAD_CODE_FRM) begin
				ea_c.seg = RAD_S_STACK; // see RULE_14
			end
		end
	end

	// ----------------------------------------
	// apb slave, one access cycle, no waits
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
		end else begin
			pready_q <= setup;
		end
	end

	// read-only words refuse writes so software sees a misdirected store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_q <= 1'b0;
		end else begin
			pslverr_q <= setup && (!mapped || (pwrite && paddr != `RAD_OFF_INSN));
		end
	end

	// read data captured in setup so the answer leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			unique case (paddr)
				`RAD_OFF_INSN: prdata_q <= insn_q;
				`RAD_OFF_REG:  prdata_q <= reg_c;
				`RAD_OFF_EA:   prdata_q <= ea_c;
				default:       prdata_q <= 32'h0000_0000;
			endcase
		end
	end

	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign prdata  = prdata_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_ANSWER_NEXT: assert property ( // see RULE_19
		setup |=> pready && !$past(pready)
	) else $error("apb answer not one cycle after setup");

	AST_WRITE_STORES: assert property ( // see RULE_17
		(wr_now && paddr == `RAD_OFF_INSN) |=> insn_q == $past(pwdata)
	) else $error("instruction word not stored");

	AST_READ_DECODE: assert property ( // see RULE_19
		(setup && !pwrite && paddr == `RAD_OFF_EA) |=> prdata == $past(ea_c)
	) else $error("address form read wrong");

	AST_SIB_WHEN: assert property ( // see RULE_08
		!insn_q.fixed_addr |-> ea_c.sib_need == (!insn_q.a16
			&& insn_q.modrm[2:0] == 3'h4 && insn_q.modrm[7:6] != 2'h3)
	) else $error("sib expectation wrong");

	AST_SEG_TWO: assert property ( // see RULE_05
		!insn_q.seg3 |-> reg_c.seg == {1'b0, insn_q.seg_code[1:0]} && !reg_c.seg_bad
	) else $error("two-bit segment decode wrong");

	AST_SEG_BAD: assert property ( // see RULE_06
		(insn_q.seg3 && insn_q.seg_code[2:1] == 2'h3) |-> reg_c.seg_bad
	) else $error("unused segment code not flagged");

	AST_BYTE_HIGH: assert property ( // see RULE_03
		(insn_q.reg_src == 2'h0 && insn_q.w_present && !insn_q.w && insn_q.op_reg[2])
		|-> reg_c.sel.width == RAD_W_BHI && reg_c.sel.idx == {1'b0, insn_q.op_reg[1:0]}
	) else $error("high byte register wrong");

	AST_BARE_D32: assert property ( // see RULE_13
		(!insn_q.fixed_addr && !insn_q.a16 && insn_q.modrm[7:6] == 2'h0
			&& insn_q.modrm[2:0] == 3'h5) |-> ea_c.disp == RAD_D_32 && !ea_c.base_ok
			&& ea_c.seg == RAD_S_DATA
	) else $error("bare displacement form wrong");

	AST_FRAME_STACK: assert property ( // see RULE_14
		(!insn_q.fixed_addr && !insn_q.a16 && insn_q.modrm[7:6] == 2'h1
			&& insn_q.modrm[2:0] == 3'h5) |-> ea_c.seg == RAD_S_STACK
			&& ea_c.base == 3'h5 && ea_c.disp == RAD_D_8
	) else $error("frame base form wrong");

	AST_REG_HALF: assert property ( // see RULE_16
		(!insn_q.fixed_addr && insn_q.modrm[7:6] == 2'h3 && insn_q.p66
			&& insn_q.w_present && insn_q.w) |-> ea_c.reg_direct
			&& ea_c.rm_sel.width == RAD_W_16
	) else $error("16-bit register operand wrong");

	AST_FULL_NO_SIZE: assert property ( // see RULE_02
		(insn_q.reg_src == 2'h0 && !insn_q.w_present) |-> reg_c.sel.idx == insn_q.op_reg
			&& reg_c.sel.width == (insn_q.p66 ? RAD_W_16 : RAD_W_32)
	) else $error("register without size bit wrong");

	AST_FIXED_STACK: assert property ( // see RULE_07
		insn_q.fixed_addr |-> ea_c.seg == RAD_S_STACK && ea_c.base == `RAD_IDX_SP
			&& ea_c.base_ok && ea_c.disp == RAD_D_NONE && !ea_c.sib_need
	) else $error("predetermined addressing wrong");

	AST_SIB_FIELDS: assert property ( // see RULE_09
		ea_c.sib_need |-> ea_c.scale == insn_q.sib[7:6] && ea_c.idx == insn_q.sib[5:3]
			&& ea_c.base == insn_q.sib[2:0]
	) else $error("scaled index fields wrong");

	AST_EXT_NO_REG: assert property ( // see RULE_10
		(insn_q.reg_src == 2'h1 && insn_q.reg_is_ext) |-> !reg_c.reg_ok
	) else $error("opcode extension taken as register");

	AST_A16_DISP: assert property ( // see RULE_12
		(!insn_q.fixed_addr && insn_q.a16 && insn_q.modrm[7:6] == 2'h1)
			|-> ea_c.disp == RAD_D_8 && !ea_c.sib_need
	) else $error("16-bit short displacement wrong");

	AST_REG_BYTE: assert property ( // see RULE_15
		(!insn_q.fixed_addr && insn_q.modrm[7:6] == 2'h3 && insn_q.w_present && !insn_q.w)
			|-> ea_c.reg_direct && ea_c.rm_sel.idx == {1'b0, insn_q.modrm[1:0]}
			&& ea_c.rm_sel.width == (insn_q.modrm[2] ? RAD_W_BHI : RAD_W_BLO)
	) else $error("byte register operand wrong");

	COV_SIB_READ: cover property (
		ea_c.sib_need && setup && paddr == `RAD_OFF_EA ##1 pready
	);
	COV_BAD_WRITE: cover property (pready && pslverr && pwrite);
	COV_SEG_BAD: cover property (reg_c.seg_bad && setup && paddr == `RAD_OFF_REG ##1 pready);
	COV_WRITE_READ: cover property (wr_now ##1 setup && !pwrite ##1 pready);

endmodule : rad_top
`default_nettype wire

// >>> pkg/rad_defs.svh
// register offsets, reset values and bus constants for the operand decoder
`ifndef RAD_DEFS_SVH
`define RAD_DEFS_SVH

`define RAD_ADDR_W    12
`define RAD_OFF_INSN  12'h000
`define RAD_OFF_REG   12'h004
`define RAD_OFF_EA    12'h008
`define RAD_INSN_RST  32'h0000_0000
`define RAD_CODE_SIB  3'h4
`define RAD_CODE_FRM  3'h5
`define RAD_CODE_D16  3'h6
`define RAD_IDX_SP    3'h4
`define RAD_IDX_FB    3'h5

`endif

// >>> pkg/rad_pkg.sv
// types shared by the operand decoder
`default_nettype none
package rad_pkg;
	typedef enum logic [1:0] {
		RAD_W_BLO = 2'h0,
		RAD_W_BHI = 2'h1,
		RAD_W_16  = 2'h2,
		RAD_W_32  = 2'h3
	} rad_width_t;

	typedef enum logic [1:0] {
		RAD_D_NONE = 2'h0,
		RAD_D_8    = 2'h1,
		RAD_D_16   = 2'h2,
		RAD_D_32   = 2'h3
	} rad_disp_t;

	typedef enum logic [2:0] {
		RAD_S_EXTRA = 3'h0,
		RAD_S_CODE  = 3'h1,
		RAD_S_STACK = 3'h2,
		RAD_S_DATA  = 3'h3,
		RAD_S_FOURTH = 3'h4,
		RAD_S_FIFTH = 3'h5
	} rad_seg_t;

	typedef enum logic [1:0] {
		RAD_SRC_OPC = 2'h0,
		RAD_SRC_MREG = 2'h1,
		RAD_SRC_MRM = 2'h2
	} rad_src_t;

	typedef struct packed {
		logic [7:0] sib;
		logic       rsvd;
		logic [2:0] seg_code;
		logic       seg3;
		logic       fixed_addr;
		logic       reg_is_ext;
		logic       a16;
		logic       p66;
		logic       w;
		logic       w_present;
		logic [1:0] reg_src;
		logic [2:0] op_reg;
		logic [7:0] modrm;
	} rad_insn_t;

	typedef struct packed {
		rad_width_t width;
		logic [2:0] idx;
	} rad_regsel_t;

	typedef struct packed {
		logic [21:0] rsvd;
		logic        seg_bad;
		rad_seg_t    seg;
		logic        reg_ok;
		rad_regsel_t sel;
	} rad_reg_t;

	typedef struct packed {
		logic [7:0]  rsvd;
		rad_regsel_t rm_sel;
		logic        fixed_addr;
		logic        a16;
		logic        reg_direct;
		rad_seg_t    seg;
		logic [1:0]  scale;
		logic        idx_ok;
		logic [2:0]  idx;
		logic        base_ok;
		logic [2:0]  base;
		rad_disp_t   disp;
		logic        sib_need;
	} rad_ea_t;
endpackage : rad_pkg
`default_nettype wire

// >>> verification/rad_feed.sv
// apb master model standing in for the stage that loads instruction words
`timescale 1ns/1ps
`default_nettype none

module rad_feed (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb request
	output var logic         psel,
	output var logic         penable,
	output var logic         pwrite,
	output var logic [11:0]  paddr,
	output var logic [31:0]  pwdata,
	// apb answer
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata
);
	logic hung;

	initial begin
		{psel, penable, pwrite, hung} = '0;
		paddr = '0;
		pwdata = '0;
	end

	// answer taken at the rising edge; the slave's flops still show what they launched
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		hung = (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// stale data inverted so a late read of it shows up
		pwdata <= ~d;
	endtask : xfer
endmodule : rad_feed
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the operand decoder over its register port
`timescale 1ns/1ps
`default_nettype none
`include "rad_defs.svh"

module tb_top
	import rad_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, bytes;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  m;
	logic [2:0]  r, b, g, code;
	int          miscompares, checks_done, src;
	rad_insn_t   ins;
	rad_reg_t    rg, rge, rgm;
	rad_ea_t     ea, eme, eam;

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	rad_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata));
	rad_feed feed (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata));

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
		feed.xfer(wr, a, d, rd, er);
		if (feed.hung) begin
			miscompares++;
			give_verdict();
		end
	endtask : acc

	task automatic load(input rad_insn_t w);
		acc(1'b1, `RAD_OFF_INSN, w);
		acc(1'b0, `RAD_OFF_REG, 32'h0);
		rg = rad_reg_t'(rd);
		acc(1'b0, `RAD_OFF_EA, 32'h0);
		ea = rad_ea_t'(rd);
	endtask : load

	initial begin
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, `RAD_OFF_INSN, 32'h0);
		check("insn reset", rd, `RAD_INSN_RST);
		check("read answer ok", er, 1'b0);
		// --------------------------------------------
		// register and segment selects
		// --------------------------------------------
		for (int i = 0; i < 64; i++) begin
			code = i[2:0];
			src = i % 3;
			ins = '0;
			{ins.p66, ins.w_present, ins.w} = i[5:3];
			ins.reg_src = 2'(src);
			ins.op_reg = (src == 0) ? code : ~code;
			ins.modrm = {2'h3, (src == 1) ? code : ~code, (src == 2) ? code : ~code};
			ins.seg3 = code[2] | i[5];
			ins.seg_code = code;
			load(ins);
			bytes = i[4] && !i[3];
			rgm = '1;
			rgm.rsvd = '0;
			rge = '0;
			rge.reg_ok = 1'b1;
			rge.sel.idx = bytes ? {1'b0, code[1:0]} : code;
			rge.sel.width = bytes ? (code[2] ? RAD_W_BHI : RAD_W_BLO) : (i[5] ? RAD_W_16 : RAD_W_32);
			rge.seg = rad_seg_t'(code);
			rge.seg_bad = ins.seg3 && code[2:1] == 2'h3;
			if (rge.seg_bad) rgm.seg = rad_seg_t'(3'h0);
			check("reg decode", rg & rgm, rge & rgm);
		end
		for (int k = 0; k < 2; k++) begin
			ins = '0;
			ins.reg_src = k ? 2'h2 : 2'h1;
			ins.reg_is_ext = !k;
			load(ins);
			check("reg valid", rg.reg_ok, 1'b0);
		end
		// --------------------------------------------
		// address forms
		// --------------------------------------------
		for (int j = 0; j < 6; j++) begin
			m = 2'(j % 3);
			r = (j < 3) ? 3'h6 : 3'h4;
			ins = '0;
			ins.a16 = 1'b1;
			ins.modrm = {m, 3'h0, r};
			load(ins);
			check("a16 form", {ea.a16, ea.sib_need, ea.disp}, {2'b10, (m == 1) ? RAD_D_8 :
				(m == 2 || r == 6) ? RAD_D_16 : RAD_D_NONE});
		end
		ins = '0;
		ins.fixed_addr = 1'b1;
		ins.modrm = 8'h05;
		load(ins);
		check("fixed", {ea.seg, ea.base, ea.disp}, {RAD_S_STACK, 3'h4, RAD_D_NONE});
		for (int i = 0; i < 256; i++) begin
			{m, r, b} = i[7:0];
			ins = '0;
			{ins.w_present, ins.w, ins.p66} = {1'b1, b[1:0]};
			ins.reg_src = 2'h2;
			ins.modrm = {m, 3'h0, r};
			ins.sib = {m, ~b, b};
			load(ins);
			eme = '0;
			eam = '0;
			{eam.sib_need, eam.a16, eam.reg_direct, eam.fixed_addr} = 4'hf;
			eam.disp = rad_disp_t'(2'h3);
			eme.sib_need = (m != 3 && r == 4);
			eme.reg_direct = (m == 3);
			if (m == 3) begin
				bytes = !b[1];
				eam.rm_sel = '1;
				eme.rm_sel.idx = bytes ? {1'b0, r[1:0]} : r;
				eme.rm_sel.width = bytes ? (r[2] ? RAD_W_BHI : RAD_W_BLO) : (b[0] ? RAD_W_16 : RAD_W_32);
			end else begin
				g = eme.sib_need ? b : r;
				eme.disp = (m == 1) ? RAD_D_8 : (m == 2 || g == 5) ? RAD_D_32 : RAD_D_NONE;
				eme.base_ok = !(m == 0 && g == 5);
				eme.base = g;
				eam.base = {3{eme.base_ok}};
				eam.base_ok = 1'b1;
				eam.seg = rad_seg_t'(3'h7);
				eme.seg = (g == 5 && m != 0 || eme.sib_need && g == 4) ? RAD_S_STACK : RAD_S_DATA;
				if (eme.sib_need) begin
					{eam.idx, eam.idx_ok, eam.scale} = 6'h3f;
					{eme.idx, eme.idx_ok, eme.scale} = {~b, ~b != 3'h4, m};
				end
			end
			check("ea decode", ea & eam, eme & eam);
		end
		// --------------------------------------------
		// refused accesses
		// --------------------------------------------
		acc(1'b1, `RAD_OFF_REG, 32'hffff_ffff);
		check("ro write err", er, 1'b1);
		acc(1'b0, 12'h00c, 32'h0);
		check("unmapped err", er, 1'b1);
		check("unmapped read", rd, 32'h0000_0000);
		acc(1'b0, `RAD_OFF_INSN, 32'h0);
		check("insn kept", rd, ins);
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
